/* File: ust_pkg.sv */
package ust_pkg;
  // ****************************************************
  // Register map: printed offsets are word indices
  // ****************************************************
  localparam logic [11:0] IDX_MODE = 12'h220;
  localparam logic [11:0] IDX_STA  = 12'h222;
  localparam logic [11:0] IDX_TXD  = 12'h224;
  localparam logic [11:0] IDX_RXD  = 12'h226;
  localparam logic [11:0] IDX_BRG  = 12'h228;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] STA_RST  = 16'h0110;
  localparam logic [15:0] BRG_RST  = 16'h0000;
  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int MODE_IR    = 12;
  localparam int MODE_FMT   = 1;
  localparam int MODE_STOP  = 0;
  localparam int STA_TXI_HI = 15;
  localparam int STA_TXPOL  = 14;
  localparam int STA_TXI_LO = 13;
  localparam int STA_BRK    = 11;
  localparam int STA_TXEN   = 10;
  localparam int STA_TXBF   = 9;
  localparam int STA_TX_SHIFTER_EMPTY   = 8;
  localparam int STA_RXI    = 6;
  localparam int STA_ADDRESS_DETECT_ENABLE  = 5;
  localparam int STA_RECEIVER_IDLE  = 4;
  localparam int STA_PARITY_ERROR_FLAG   = 3;
  localparam int STA_FRAMING_ERROR_FLAG   = 2;
  localparam int STA_OVERRUN_FLAG   = 1;
  localparam int STA_RXDA   = 0;
  // ****************************************************
  // Modes and timing counts
  // ****************************************************
  typedef enum logic [1:0] {
    FMT_8N = 2'b00, FMT_8E = 2'b01, FMT_8O = 2'b10, FMT_9N = 2'b11
  } ust_fmt_type;
  localparam logic [1:0] TXI_LOAD  = 2'b00;
  localparam logic [1:0] TXI_DONE  = 2'b01;
  localparam logic [1:0] TXI_EMPTY = 2'b10;
  localparam logic [3:0] TICK_LAST = 4'hf;  // 16 ticks per bit
  localparam logic [3:0] MID_TICK  = 4'h7;
  localparam logic [3:0] IR_PULSE  = 4'h3;  // 3/16 bit pulse
  localparam logic [3:0] BRK_LEN   = 4'he;  // start, 12 zeros, stop

  // Frame bits, least significant sent first; 1s pad the tail
  function automatic logic [13:0] ust_frame(logic [1:0] fmt,
                                            logic [8:0] d);
    logic [13:0] f;
    f = 14'h3fff;
    f[0] = 1'b0;
    f[8:1] = d[7:0];
    case (fmt)
      FMT_9N:  f[9] = d[8];
      FMT_8E:  f[9] = ^d[7:0];
      FMT_8O:  f[9] = ~^d[7:0];
      default: f[9] = 1'b1;
    endcase
    return f;
  endfunction

  // Total bits per frame including start and stops
  function automatic logic [3:0] ust_len(logic [1:0] fmt, logic two);
    return 4'ha + {3'h0, fmt != FMT_8N} + {3'h0, two};
  endfunction
endpackage

/* File: ust_link_if.sv */
`timescale 1ns/1ps
interface ust_link_if;
  logic dev_tx;
  logic dev_tx_oe;
  logic host_tx;
  logic dev_line;
  // Undriven device pin rests high through the pad pull-up
  assign dev_line = dev_tx_oe ? dev_tx : 1'b1;
  modport dev (output dev_tx, output dev_tx_oe, input host_tx);
  modport host (input dev_line, output host_tx);
endinterface

/* File: ust_dev.sv */
`timescale 1ns/1ps
// Behaviour
// - Format field picks data and parity
// - Stop select gives one or two stops
// - Tx mode 00: event per shifter load
// - Tx mode 01: event when all sent
// - Tx mode 10: event when load empties buffer
// - Software never writes tx mode 11
// - Infrared idle level follows polarity bit
// - Break: start, twelve zeros, stop; self-clears
// - Disable aborts, flushes, releases tx pin
// - Buffer full flag when no slot free
// - Shifter empty when shifter, buffer empty
// - Rx mode 11: event at four characters
// - Rx mode 10: event at three characters
// - Rx mode 0x: event per character
// - Address detect only in 9-bit format
// - Receiver idle flag while not receiving
// - Parity error of head character
// - Framing error of head character
// - Overrun set; clearing flushes receiver
// - Data available when buffer non-empty
// - Reading data advances head and flags
// - Break dummy, then 55h sent after
module ust_dev #(
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // Events to the interrupt controller
  output      logic        tx_irq,
  output      logic        rx_irq,
  // Serial link
  ust_link_if.dev          link
);
  import ust_pkg::*;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_WAIT = 2'b11
  } ust_rx_type;

  // ****************************************************
  // Register bus
  // ****************************************************
  logic [15:0] mode, sta_ctl, brg;
  logic        overrun;
  wire  setup    = psel & ~penable;
  wire  access   = psel & penable & pready;
  wire  word_ok  = paddr[15:14] == 2'b00 && paddr[1:0] == 2'b00;
  wire  hit_mode = word_ok && paddr[13:2] == IDX_MODE;
  wire  hit_sta  = word_ok && paddr[13:2] == IDX_STA;
  wire  hit_txd  = word_ok && paddr[13:2] == IDX_TXD;
  wire  hit_rxd  = word_ok && paddr[13:2] == IDX_RXD;
  wire  hit_brg  = word_ok && paddr[13:2] == IDX_BRG;
  wire  mapped   = hit_mode | hit_sta | hit_txd | hit_rxd | hit_brg;
  wire  wr       = access & pwrite & mapped;
  wire  wr_sta   = wr & hit_sta;
  wire  rd_rxd   = access & ~pwrite & hit_rxd;
  wire [1:0] fmt = mode[MODE_FMT+:2];
  wire  two_stop = mode[MODE_STOP];
  wire  ir_en    = mode[MODE_IR];
  wire  tx_en    = sta_ctl[STA_TXEN];
  wire  brk_req  = sta_ctl[STA_BRK];
  wire [1:0] txi = {sta_ctl[STA_TXI_HI], sta_ctl[STA_TXI_LO]};
  wire [1:0] rxi = sta_ctl[STA_RXI+:2];

  // ****************************************************
  // Buffers
  // ****************************************************
  localparam int PW = $clog2(DEPTH);
  logic [8:0]  txq [DEPTH];
  logic [10:0] rxq [DEPTH];  // {framing, parity, data}
  logic [PW-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
  logic [PW:0]   tx_cnt, rx_cnt;
  logic tx_pop, rx_push, rx_flush, tx_was_en;
  logic [10:0] rx_word;
  wire  tx_full  = tx_cnt == (PW+1)'(DEPTH);
  wire  tx_empty = tx_cnt == '0;
  wire  rx_full  = rx_cnt == (PW+1)'(DEPTH);
  wire  rx_avail = rx_cnt != '0;
  wire  tx_push  = wr & hit_txd & ~tx_full;
  wire  tx_flush = tx_was_en & ~tx_en;
  wire  rx_pop   = rd_rxd & rx_avail;
  wire  ovf      = rx_push & rx_full & ~rx_pop;
  wire  rx_store = rx_push & ~ovf;
  wire  overrun_flag_clr = wr_sta & overrun & ~pwdata[STA_OVERRUN_FLAG];
  // Storage has no reset, so an empty buffer must read as zero
  wire [10:0] rx_head = rx_avail ? rxq[rx_rp] : 11'h0;

  // Transmit queue; a disable throws away what is queued
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_cnt <= '0;
      tx_was_en <= 1'b0;
    end else begin
      tx_was_en <= tx_en;
      if (tx_flush) begin
        tx_wp <= '0;
        tx_rp <= '0;
        tx_cnt <= '0;
      end else begin
        if (tx_push) tx_wp <= tx_wp + 1'b1;
        if (tx_pop) tx_rp <= tx_rp + 1'b1;
        tx_cnt <= tx_cnt + (PW+1)'(tx_push) - (PW+1)'(tx_pop);
      end
    end
  end

  // Receive queue; a clear of overrun empties it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= '0;
    end else if (rx_flush) begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= '0;
    end else begin
      if (rx_store) rx_wp <= rx_wp + 1'b1;
      if (rx_pop) rx_rp <= rx_rp + 1'b1;
      rx_cnt <= rx_cnt + (PW+1)'(rx_store) - (PW+1)'(rx_pop);
    end
  end

  // Storage needs no reset; pointers qualify every read
  always_ff @(posedge clk) begin
    if (tx_push) txq[tx_wp] <= pwdata[8:0];
    if (rx_store) rxq[rx_wp] <= rx_word;
  end

  // ****************************************************
  // Bit rate ticks, 16 per bit
  // ****************************************************
  logic [15:0] bcnt;
  logic        tick;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bcnt <= '0;
      tick <= 1'b0;
    end else begin
      // Restart on divisor write so a new rate takes at once
      tick <= ~(wr & hit_brg) & (bcnt == brg);
      bcnt <= (wr & hit_brg) || bcnt == brg ? 16'h0 : bcnt + 16'h1;
    end
  end

  // ****************************************************
  // Transmitter
  // ****************************************************
  typedef enum logic {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} ust_tx_type;
  ust_tx_type tx_st;
  logic [13:0] tx_sh;
  logic [3:0]  tx_left, tx_sub;
  logic        tx_brk, brk_done, tx_done, tx_pin;
  // Wait one cycle after a break so the cleared bit is seen
  wire  tx_load  = tx_st == TX_IDLE && tx_en && !tx_empty && !tx_flush
                   && !brk_done;
  wire  bit_end  = tick && tx_sub == TICK_LAST;
  wire  last_bit = bit_end && tx_left == 4'h1;
  assign tx_pop  = tx_load;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_st <= TX_IDLE;
      tx_sh <= '1;
      tx_left <= '0;
      tx_sub <= '0;
      tx_brk <= 1'b0;
      brk_done <= 1'b0;
      tx_done <= 1'b0;
    end else begin
      brk_done <= 1'b0;
      tx_done <= 1'b0;
      if (!tx_en) begin
        tx_st <= TX_IDLE;
        tx_sh <= '1;
        tx_brk <= 1'b0;
      end else if (tx_load) begin
        tx_st <= TX_SHIFT;
        tx_sub <= '0;
        tx_brk <= brk_req;
        // Break replaces the queued dummy character
        tx_sh <= brk_req ? 14'h2000 : ust_frame(fmt, txq[tx_rp]);
        tx_left <= brk_req ? BRK_LEN : ust_len(fmt, two_stop);
      end else if (tx_st == TX_SHIFT && tick) begin
        tx_sub <= tx_sub + 4'h1;
        if (bit_end) begin
          tx_sh <= {1'b1, tx_sh[13:1]};
          tx_left <= tx_left - 4'h1;
        end
        if (last_bit) begin
          tx_st <= TX_IDLE;
          brk_done <= tx_brk;
          tx_done <= 1'b1;
        end
      end
    end
  end

  // Pin drive; infrared sends short pulses for zeros only
  wire raw_bit = tx_st == TX_SHIFT ? tx_sh[0] : 1'b1;
  wire ir_bit  = ~raw_bit && tx_sub < IR_PULSE;
  wire pol     = sta_ctl[STA_TXPOL];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) tx_pin <= 1'b1;
    else tx_pin <= ir_en ? ir_bit ^ pol : raw_bit;
  end
  assign link.dev_tx = tx_pin;
  assign link.dev_tx_oe = tx_was_en;

  // ****************************************************
  // Receiver
  // ****************************************************
  logic [2:0] rx_sync;
  logic       rx_line;
  ust_rx_type rx_st;
  logic [3:0] rx_sub, rx_idx;
  logic [9:0] rx_sh;
  wire [3:0] rx_last = ust_len(fmt, 1'b0) - 4'h2;  // index of stop
  wire       mid     = tick && rx_sub == TICK_LAST;
  // Address detect is active only for 9-bit characters
  wire       drop    = sta_ctl[STA_ADDRESS_DETECT_ENABLE] && fmt == FMT_9N
                       && !rx_sh[8];
  wire       parity_error_flag_c  = (fmt == FMT_8E && ^rx_sh[8:0])
                       || (fmt == FMT_8O && ~^rx_sh[8:0]);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_sync <= 3'b111;
      rx_line <= 1'b1;
    end else begin
      rx_sync <= {rx_sync[1:0], link.host_tx};
      if (rx_sync[2] == rx_sync[1]) rx_line <= rx_sync[2];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_st <= RX_IDLE;
      rx_sub <= '0;
      rx_idx <= '0;
      rx_sh <= '0;
      rx_push <= 1'b0;
      rx_word <= '0;
    end else begin
      rx_push <= 1'b0;
      if (rx_flush) begin
        rx_st <= RX_WAIT;
      end else case (rx_st)
        RX_IDLE: begin
          rx_sub <= '0;
          rx_idx <= '0;
          if (!rx_line) rx_st <= RX_START;
        end
        RX_START: if (tick) begin
          rx_sub <= rx_sub + 4'h1;
          if (rx_sub == MID_TICK) begin
            rx_sub <= '0;  // Realign on the middle of start
            rx_st <= rx_line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: if (tick) begin
          rx_sub <= rx_sub + 4'h1;
          if (mid) begin
            rx_idx <= rx_idx + 4'h1;
            if (rx_idx != rx_last) rx_sh[rx_idx] <= rx_line;
            else begin
              rx_st <= rx_line ? RX_IDLE : RX_WAIT;
              rx_push <= ~drop;
              rx_word <= {~rx_line, parity_error_flag_c,
                          (fmt == FMT_9N) & rx_sh[8], rx_sh[7:0]};
            end
          end
        end
        RX_WAIT: if (rx_line) rx_st <= RX_IDLE;
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  // ****************************************************
  // Control, status, events and read data
  // ****************************************************
  wire [PW:0] rx_after = rx_cnt + (PW+1)'(rx_store) - (PW+1)'(rx_pop);
  wire rx_ev = rx_store && (!rxi[1]
               || (rxi == 2'b11 && rx_after == (PW+1)'(4))
               || (rxi == 2'b10 && rx_after == (PW+1)'(3)));
  wire tx_ev = (txi == TXI_LOAD && tx_load)
               || (txi == TXI_EMPTY && tx_load
                   && tx_cnt == (PW+1)'(1) && !tx_push)
               || (txi == TXI_DONE && tx_done
                   && tx_empty);
  wire tx_shifter_empty = tx_st == TX_IDLE && tx_empty;
  wire [15:0] sta_rd = {sta_ctl[15:10], tx_full, tx_shifter_empty,
                        sta_ctl[7:5], rx_st == RX_IDLE,
                        rx_head[9], rx_head[10], overrun,
                        rx_avail};
  wire [15:0] rd_val = hit_mode ? mode : hit_sta ? sta_rd :
                       hit_rxd ? {7'h0, rx_head[8:0]} :
                       hit_brg ? brg : 16'h0;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode <= MODE_RST;
      sta_ctl <= STA_RST;
      brg <= BRG_RST;
      overrun <= 1'b0;
      rx_flush <= 1'b0;
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      if (wr & hit_mode) mode <= pwdata[15:0] & 16'h1007;
      if (wr & hit_brg) brg <= pwdata[15:0];
      if (wr_sta) sta_ctl <= pwdata[15:0] & 16'hece0;
      else if (brk_done) sta_ctl[STA_BRK] <= 1'b0;
      // A new overflow wins over a clear in the same cycle
      overrun <= ovf | (overrun & ~overrun_flag_clr);
      rx_flush <= overrun_flag_clr & ~ovf;
      tx_irq <= tx_ev;
      rx_irq <= rx_ev;
      pready <= setup;  // One wait-free access phase
      pslverr <= setup & ~mapped;
      prdata <= setup ? {16'h0, rd_val} : 32'h0;
    end
  end
endmodule // ust_dev

/* File: ust_host.sv */
`timescale 1ns/1ps
module ust_host (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Line settings, matching the device
  input  wire logic [15:0] divisor,
  input  wire logic [1:0]  char_format,
  input  wire logic        two_stop,
  // Send request
  input  wire logic        send_valid,
  input  wire logic [8:0]  send_data,
  output      logic        send_ready,
  // Received character, one-cycle strobe
  output      logic        recv_valid,
  output      logic [8:0]  recv_data,
  output      logic        recv_parity_error_flag,
  output      logic        recv_framing_error_flag,
  // Serial link
  ust_link_if.host         link
);
  import ust_pkg::*;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_WAIT = 2'b11
  } ust_rx_type;

  // ****************************************************
  // Bit rate ticks
  // ****************************************************
  logic [15:0] bcnt;
  logic        tick;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bcnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= bcnt == divisor;
      bcnt <= bcnt >= divisor ? 16'h0 : bcnt + 16'h1;
    end
  end

  // ****************************************************
  // Transmitter, one character at a time
  // ****************************************************
  logic [13:0] sh;
  logic [3:0]  left, sub;
  logic        tx_pin;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      send_ready <= 1'b1;
      sh <= '1;
      left <= '0;
      sub <= '0;
      tx_pin <= 1'b1;
    end else begin
      tx_pin <= send_ready ? 1'b1 : sh[0];
      if (send_ready && send_valid) begin
        send_ready <= 1'b0;
        sub <= '0;
        sh <= ust_frame(char_format, send_data);
        left <= ust_len(char_format, two_stop);
      end else if (!send_ready && tick) begin
        sub <= sub + 4'h1;
        if (sub == TICK_LAST) begin
          sh <= {1'b1, sh[13:1]};
          left <= left - 4'h1;
          if (left == 4'h1) send_ready <= 1'b1;
        end
      end
    end
  end
  assign link.host_tx = tx_pin;

  // ****************************************************
  // Receiver; a break reads as a framing error
  // ****************************************************
  logic [2:0] sync;
  logic       line;
  ust_rx_type st;
  logic [3:0] rsub, idx;
  logic [9:0] rsh;
  wire [3:0] last = ust_len(char_format, 1'b0) - 4'h2;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync <= 3'b111;
      line <= 1'b1;
    end else begin
      sync <= {sync[1:0], link.dev_line};
      if (sync[2] == sync[1]) line <= sync[2];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= RX_IDLE;
      rsub <= '0;
      idx <= '0;
      rsh <= '0;
      recv_valid <= 1'b0;
      recv_data <= '0;
      recv_parity_error_flag <= 1'b0;
      recv_framing_error_flag <= 1'b0;
    end else begin
      recv_valid <= 1'b0;
      case (st)
        RX_IDLE: begin
          rsub <= '0;
          idx <= '0;
          if (!line) st <= RX_START;
        end
        RX_START: if (tick) begin
          rsub <= rsub + 4'h1;
          if (rsub == MID_TICK) begin
            rsub <= '0;
            st <= line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: if (tick) begin
          rsub <= rsub + 4'h1;
          if (rsub == TICK_LAST) begin
            idx <= idx + 4'h1;
            if (idx != last) rsh[idx] <= line;
            else begin
              st <= line ? RX_IDLE : RX_WAIT;
              recv_valid <= 1'b1;
              recv_framing_error_flag <= ~line;
              recv_data <= {(char_format == FMT_9N) & rsh[8], rsh[7:0]};
              recv_parity_error_flag <= (char_format == FMT_8E && ^rsh[8:0])
                           || (char_format == FMT_8O && ~^rsh[8:0]);
            end
          end
        end
        RX_WAIT: if (line) st <= RX_IDLE;
        default: st <= RX_IDLE;
      endcase
    end
  end
endmodule // ust_host

/* File: ust_link_properties.sv */
`timescale 1ns/1ps
// ****************************************
// Link wire checks
// ****************************************
module ust_link_properties #(
  parameter int BRK_MAX = 416
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Link wires
  input wire logic dev_tx,
  input wire logic dev_tx_oe,
  input wire logic host_tx,
  input wire logic dev_line
);
  int lo_run;

  // Low run on the line; a break is the longest legal one
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lo_run <= 0;
    end else begin
      lo_run <= dev_line ? 0 : lo_run + 1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_pin_released: assert property (!dev_tx_oe |-> dev_line)
    else $error("line not high while pin released");
  a_pin_follows: assert property (dev_tx_oe |-> dev_line == dev_tx)
    else $error("line differs from driven level");
  a_break_bound: assert property (lo_run <= BRK_MAX)
    else $error("line low longer than a break");
  a_dev_low_hold: assert property ($fell(dev_tx) |=> !dev_tx [*2])
    else $error("device low level too short");
  a_dev_high_hold: assert property ($rose(dev_tx) |=> dev_tx [*2])
    else $error("device high level too short");
  a_host_bit_low: assert property ($fell(host_tx) |=> !host_tx [*8])
    else $error("host low bit too short");
  a_host_bit_high: assert property ($rose(host_tx) |=> host_tx [*8])
    else $error("host high bit too short");
  a_reset_idle: assert property ($rose(rstn) |-> host_tx && !dev_tx_oe)
    else $error("link not idle after reset");

  // Main scenarios seen on the wire
  c_break: cover property (lo_run == BRK_MAX - 16);
  c_enable: cover property ($rose(dev_tx_oe));
  c_host_frame: cover property ($fell(host_tx));
endmodule // ust_link_properties

/* File: uart_status_control_framing_tb.sv */
`timescale 1ns/1ps
// ****************************************
// Bench: device and host across the link
// ****************************************
module uart_status_control_framing_tb;
  import ust_pkg::*;
  localparam int DIV = 1;
  localparam int BIT = 16 * (DIV + 1);
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, e;
  logic        tx_irq, rx_irq, h_two, s_valid, s_ready, r_valid;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [1:0]  h_fmt;
  logic [8:0]  s_data, r_data, last_d, d, msk;
  logic [13:0] fr, ef;
  int          n_errors, checks, n_tx, n_rx, n_rcv, b, c, k;
  ust_link_if lk ();
  ust_dev u_ust_dev (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_irq(tx_irq), .rx_irq(rx_irq), .link(lk.dev));
  ust_host u_ust_host (.clk(clk), .rstn(rstn), .divisor(16'(DIV)),
    .char_format(h_fmt), .two_stop(h_two), .send_valid(s_valid),
    .send_data(s_data), .send_ready(s_ready), .recv_valid(r_valid),
    .recv_data(r_data), .recv_parity_error_flag(), .recv_framing_error_flag(), .link(lk.host));
  ust_link_properties #(.BRK_MAX(13 * BIT)) u_ust_link_properties (
    .clk(clk), .rstn(rstn), .dev_tx(lk.dev_tx), .dev_tx_oe(lk.dev_tx_oe),
    .host_tx(lk.host_tx), .dev_line(lk.dev_line));

  // Clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Event and receive counters
  always @(posedge clk) begin
    if (tx_irq === 1'b1) n_tx++;
    if (rx_irq === 1'b1) n_rx++;
    if (r_valid === 1'b1) n_rcv++;
    if (r_valid === 1'b1) last_d = r_data;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, g, x);
    end
  endtask
  // Bounded wait step; a hang ends the run
  task automatic step(ref int t);
    @(posedge clk);
    t++;
    if (t > 4000) begin
      n_errors++;
      $display("timeout at %0t", $time);
      results();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] i,
                     input logic [31:0] wd);
    int t;
    t = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do step(t); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] i, input logic [31:0] wd);
    apb(1'b1, i, wd);
  endtask
  task automatic rdchk(input logic [11:0] i, input logic [31:0] m, x);
    apb(1'b0, i, 32'h0);
    chk(r & m, x);
  endtask
  task automatic poll(input int n, input logic v);
    int t;
    t = 0;
    do begin
      apb(1'b0, IDX_STA, 32'h0);
      step(t);
    end while (r[n] !== v);
  endtask
  // Host sends one character and finishes its frame
  task automatic host_send(input logic [8:0] hd);
    int t;
    t = 0;
    @(posedge clk);
    s_valid <= 1'b1;
    s_data <= hd;
    do step(t); while (s_ready !== 1'b1);
    s_valid <= 1'b0;
    do step(t); while (s_ready !== 1'b1);
    repeat (4) @(posedge clk);
  endtask
  // Sample the line at each bit middle from the start bit
  task automatic grab();
    int t;
    t = 0;
    while (lk.dev_line !== 1'b0) step(t);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 14; i++) begin
      fr[i] = lk.dev_line;
      repeat (BIT) @(posedge clk);
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rstn, psel, penable, pwrite, h_two, s_valid} = 6'h0;
    {paddr, pwdata, h_fmt, s_data} = '0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rdchk(IDX_MODE, 32'hffff, 32'h0);
    rdchk(IDX_STA, 32'hffff, 32'h110);
    rdchk(IDX_RXD, 32'hffff, 32'h0);
    apb(1'b0, 12'h221, 32'h0);
    chk({31'h0, e}, 32'h1);
    wr(IDX_BRG, DIV);
    wr(IDX_STA, 32'h400);
    $display("reset test done");
    // Every format and stop count, both directions
    for (int f = 0; f < 4; f++) begin
      for (int s = 0; s < 2; s++) begin
        h_fmt <= f[1:0];
        h_two <= s[0];
        d = {f[0], 8'h96 ^ 8'(f * 5 + s)};
        msk = (f == 3) ? 9'h1ff : 9'h0ff;
        wr(IDX_MODE, f * 2 + s);
        b = n_tx;
        wr(IDX_TXD, d);
        grab();
        ef = 14'h3fff;
        ef[8:0] = {d[7:0], 1'b0};
        ef[9] = (f == 3) ? d[8] : (f == 1) ? ^d[7:0] : (f != 2) | ~^d[7:0];
        chk(fr, ef);
        chk(n_tx - b, 1);
        chk(last_d & msk, d & msk);
        host_send(d);
        rdchk(IDX_STA, 32'hd, 32'h1);
        rdchk(IDX_RXD, msk, d & msk);
      end
    end
    $display("format test done");
    // Receive event modes, then overrun and its recovery
    wr(IDX_MODE, 32'h0);
    h_fmt <= 2'b00;
    h_two <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      wr(IDX_STA, 32'h400 | (m << 6));
      b = n_rx;
      for (int i = 0; i < 5; i++) begin
        host_send(9'h030 + i);
        if (i == 2) chk(n_rx - b, m < 2 ? 3 : m == 2);
        if (i == 3) chk(n_rx - b, m < 2 ? 4 : 1);
      end
      rdchk(IDX_STA, 32'h3, 32'h3);
      rdchk(IDX_RXD, 32'h1ff, 32'h30);
      wr(IDX_STA, 32'h400);
      rdchk(IDX_STA, 32'h3, 32'h0);
    end
    $display("receive test done");
    // Transmit event modes with a full buffer
    for (int m = 0; m < 3; m++) begin
      wr(IDX_STA, 32'h400 | (m == 1 ? 32'h2000 : 32'h0)
         | (m == 2 ? 32'h8000 : 32'h0));
      b = n_tx;
      c = n_rcv;
      for (int i = 0; i < 5; i++) wr(IDX_TXD, 32'h61 + i);
      rdchk(IDX_STA, 32'h300, 32'h200);
      poll(STA_TX_SHIFTER_EMPTY, 1'b1);
      repeat (BIT) @(posedge clk);
      chk(n_tx - b, m == 0 ? 5 : m);
      chk(n_rcv - c, 5);
      chk(last_d[7:0], 32'h65);
    end
    $display("transmit test done");
    // Disable in mid-frame with characters queued
    wr(IDX_STA, 32'h400);
    for (int i = 0; i < 3; i++) wr(IDX_TXD, 32'h11);
    wr(IDX_STA, 32'h0);
    rdchk(IDX_STA, 32'h300, 32'h100);
    chk(lk.dev_tx_oe, 32'h0);
    repeat (20 * BIT) @(posedge clk);
    wr(IDX_STA, 32'h800 | 32'h400);
    wr(IDX_TXD, 32'h0);
    wr(IDX_TXD, 32'h55);
    k = 0;
    while (lk.dev_line !== 1'b0) step(k);
    k = 0;
    while (lk.dev_line === 1'b0) step(k);
    chk(k > 13 * BIT - 16 && k <= 13 * BIT, 32'h1);
    poll(STA_BRK, 1'b0);
    poll(STA_TX_SHIFTER_EMPTY, 1'b1);
    repeat (BIT) @(posedge clk);
    chk(last_d[7:0], 32'h55);
    $display("break test done");
    // Address detect in 9-bit and 8-bit formats
    wr(IDX_MODE, 32'h6);
    h_fmt <= 2'b11;
    wr(IDX_STA, 32'h420);
    host_send(9'h0aa);
    host_send(9'h1bb);
    rdchk(IDX_RXD, 32'h1ff, 32'h1bb);
    rdchk(IDX_STA, 32'h1, 32'h0);
    wr(IDX_MODE, 32'h0);
    host_send(9'h0aa);
    wr(IDX_MODE, 32'h4);
    h_fmt <= 2'b01;
    host_send(9'h055);
    rdchk(IDX_STA, 32'hd, 32'h5);
    rdchk(IDX_RXD, 32'hff, 32'haa);
    rdchk(IDX_STA, 32'hd, 32'h9);
    $display("detect and error test done");
    // Infrared idle level follows polarity only when enabled
    wr(IDX_MODE, 32'h1000);
    wr(IDX_STA, 32'h4400);
    repeat (4) @(posedge clk);
    chk(lk.dev_line, 32'h1);
    wr(IDX_STA, 32'h400);
    repeat (4) @(posedge clk);
    chk(lk.dev_line, 32'h0);
    wr(IDX_MODE, 32'h0);
    repeat (4) @(posedge clk);
    chk(lk.dev_line, 32'h1);
    $display("infrared test done");
    results();
  end
endmodule // uart_status_control_framing_tb
